// file: src/ser_pkg.sv
// Purpose: Shared types and constants for status event reporting
// Assumes: Single clock, commands decoded upstream into one-cycle pulses
// Notes: Register values are plain binary; binary-weighted decimal is that value
package ser_pkg;
  localparam int SER_WIDTH = 16;
  localparam int SER_STD_WIDTH = 8;
  localparam logic [SER_WIDTH-1:0] SER_ALL_ZERO = 16'h0000;
  localparam logic [SER_WIDTH-1:0] SER_ALL_ONE = 16'hFFFF;
  localparam logic [SER_STD_WIDTH-1:0] SER_STD_ZERO = 8'h00;

  // Register selector for writes and queries
  typedef enum logic [2:0] {
    SER_SEL_QEVENT,
    SER_SEL_QCOND,
    SER_SEL_QENABLE,
    SER_SEL_QPTR,
    SER_SEL_QNTR,
    SER_SEL_SEVENT,
    SER_SEL_SENABLE
  } ser_sel_e;

  // One command from the host parser
  typedef struct packed {
    logic write;
    logic query;
    ser_sel_e sel;
    logic [SER_WIDTH-1:0] value;
  } ser_cmd_s;

  // Global actions, one-cycle pulses
  typedef struct packed {
    logic clearStatus;
    logic afterTerminator;
    logic preset;
    logic resetCmd;
  } ser_action_s;
endpackage : ser_pkg

// file: src/ser_status_event.sv
// Purpose: Questionable status group and standard event enable with summaries
// Assumes: Inputs synchronous to clk; command and action fields are pulses
// Notes: Query answer appears one cycle after the query pulse
//
// Contract
// - Questionable event latches filtered events; a read returns then clears it.
// - Reset command leaves questionable event contents unchanged.
// - Query returns register as binary-weighted sum of set bits.
// - Condition register shows live status; reading changes nothing.
// - Condition bit follows its source, clearing when the condition goes.
// - Reset command clears condition except bits whose condition persists.
// - Questionable enable masks events into the questionable summary bit.
// - Preset clears every questionable enable bit.
// - Clear-status clears event registers, leaves enable registers.
// - Negative filter bit set: falling condition sets event bit.
// - Positive filter bit set: rising condition sets event bit.
// - Preset sets all positive filter bits, clears all negative ones.
// - Both filter bits set: either transition sets event bit.
// - Both filter bits clear: no transition sets event bit.
// - Clear-status clears all group events, status byte and error queue.
// - Clear-status after a terminator also empties output queue and MAV.
// - Standard enable ones report latched standard events through summary.
// - Standard event bit stays set until its query or clear-status.
`timescale 1ns/1ps
module ser_status_event
  import ser_pkg::*;
#(
  parameter int WIDTH = SER_WIDTH,
  parameter int STD_WIDTH = SER_STD_WIDTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] condSource,
  input wire logic [STD_WIDTH-1:0] stdEventSet,
  input wire ser_cmd_s cmd,
  input wire ser_action_s action,
  output logic [WIDTH-1:0] queryData,
  output logic queryValid,
  output logic quesSummary,
  output logic esbSummary,
  output logic clearStatusByte,
  output logic clearErrorQueue,
  output logic clearOutputQueue
);

  // ****************************************
  // Storage
  // ****************************************
  logic [WIDTH-1:0] condition;
  logic [WIDTH-1:0] quesEvent;
  logic [WIDTH-1:0] quesEnable;
  logic [WIDTH-1:0] posFilter;
  logic [WIDTH-1:0] negFilter;
  logic [STD_WIDTH-1:0] stdEvent;
  logic [STD_WIDTH-1:0] stdEnable;

  logic [WIDTH-1:0] rising;
  logic [WIDTH-1:0] falling;
  logic [WIDTH-1:0] filtered;
  logic readQuesEvent;
  logic readStdEvent;

  function automatic logic isWrite(input ser_cmd_s c, input ser_sel_e s);
    isWrite = c.write && (c.sel == s);
  endfunction : isWrite

  function automatic logic isQuery(input ser_cmd_s c, input ser_sel_e s);
    isQuery = c.query && (c.sel == s);
  endfunction : isQuery

  // ****************************************
  // Transition filter
  // ****************************************
  assign rising = ~condition & condSource;
  assign falling = condition & ~condSource;
  // Either, both or neither direction passes per bit
  assign filtered = (rising & posFilter) | (falling & negFilter);
  assign readQuesEvent = isQuery(cmd, SER_SEL_QEVENT);
  assign readStdEvent = isQuery(cmd, SER_SEL_SEVENT);

  // Live copy; a reset command reloads from source so persisting bits stay
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      condition <= SER_ALL_ZERO;
    end else if (action.resetCmd) begin
      condition <= condSource;
    end else begin
      condition <= condSource;
    end
  end

  // ****************************************
  // Event registers
  // ****************************************
  // New events OR in after the clear so none is lost; resetCmd not looked at
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      quesEvent <= SER_ALL_ZERO;
    end else if (readQuesEvent || action.clearStatus) begin
      quesEvent <= filtered;
    end else begin
      quesEvent <= quesEvent | filtered;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stdEvent <= SER_STD_ZERO;
    end else if (readStdEvent || action.clearStatus) begin
      stdEvent <= stdEventSet;
    end else begin
      stdEvent <= stdEvent | stdEventSet;
    end
  end

  // ****************************************
  // Masks and filters
  // ****************************************
  // Written value is the plain binary image of the host's decimal figure
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      quesEnable <= SER_ALL_ZERO;
    end else if (action.preset) begin
      quesEnable <= SER_ALL_ZERO;
    end else if (isWrite(cmd, SER_SEL_QENABLE)) begin
      quesEnable <= cmd.value[WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      posFilter <= SER_ALL_ONE;
      negFilter <= SER_ALL_ZERO;
    end else if (action.preset) begin
      posFilter <= SER_ALL_ONE;
      negFilter <= SER_ALL_ZERO;
    end else begin
      if (isWrite(cmd, SER_SEL_QPTR)) begin
        posFilter <= cmd.value[WIDTH-1:0];
      end
      if (isWrite(cmd, SER_SEL_QNTR)) begin
        negFilter <= cmd.value[WIDTH-1:0];
      end
    end
  end

  // Clear-status never touches enables
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stdEnable <= SER_STD_ZERO;
    end else if (isWrite(cmd, SER_SEL_SENABLE)) begin
      stdEnable <= cmd.value[STD_WIDTH-1:0];
    end
  end

  // ****************************************
  // Summaries and side actions
  // ****************************************
  // Registered, so a summary lags its event by one cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      quesSummary <= 1'b0;
      esbSummary <= 1'b0;
    end else begin
      quesSummary <= |(quesEvent & quesEnable);
      esbSummary <= |(stdEvent & stdEnable);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clearStatusByte <= 1'b0;
      clearErrorQueue <= 1'b0;
      clearOutputQueue <= 1'b0;
    end else begin
      clearStatusByte <= action.clearStatus;
      clearErrorQueue <= action.clearStatus;
      clearOutputQueue <= action.clearStatus && action.afterTerminator;
    end
  end

  // ****************************************
  // Query answer
  // ****************************************
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      queryData <= SER_ALL_ZERO;
      queryValid <= 1'b0;
    end else begin
      queryValid <= cmd.query;
      case (cmd.sel)
        SER_SEL_QEVENT: queryData <= quesEvent;
        SER_SEL_QCOND: queryData <= condition;
        SER_SEL_QENABLE: queryData <= quesEnable;
        SER_SEL_QPTR: queryData <= posFilter;
        SER_SEL_QNTR: queryData <= negFilter;
        SER_SEL_SEVENT: queryData <= {{(WIDTH-STD_WIDTH){1'b0}}, stdEvent};
        SER_SEL_SENABLE: queryData <= {{(WIDTH-STD_WIDTH){1'b0}}, stdEnable};
        default: queryData <= SER_ALL_ZERO;
      endcase
    end
  end

endmodule : ser_status_event

// file: verif/ser_host.sv
// Purpose: host model. Assumes: drives 1 ns after edge. Notes: idle cycle between calls
`timescale 1ns/1ps
module ser_host
  import ser_pkg::*;
(
  input wire logic clk,
  output ser_cmd_s cmd,
  output ser_action_s action,
  input wire logic [SER_WIDTH-1:0] queryData,
  input wire logic queryValid
);
  initial begin
    cmd = '0;
    action = '0;
  end
  // One value whose binary weights pick the bits
  task automatic wr(input ser_sel_e s, input logic [SER_WIDTH-1:0] v);
    @(posedge clk) #1 cmd = '{1'h1, 1'h0, s, v};
    @(posedge clk) #1 cmd = '0;
  endtask : wr
  task automatic qry(input ser_sel_e s, output logic [SER_WIDTH-1:0] d, output logic v);
    @(posedge clk) #1 cmd = '{1'h0, 1'h1, s, SER_ALL_ZERO};
    @(posedge clk) #1 cmd = '0;
    d = queryData;
    v = queryValid;
  endtask : qry
  task automatic act(input ser_action_s a);
    @(posedge clk) #1 action = a;
    @(posedge clk) #1 action = '0;
  endtask : act
endmodule : ser_host

// file: verif/ser_status_event_properties.sv
// Purpose: port checks. Assumes: one clock. Notes: bound below
`timescale 1ns/1ps
module ser_status_event_properties
  import ser_pkg::*;
#(parameter int WIDTH = SER_WIDTH, parameter int STD_WIDTH = SER_STD_WIDTH) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] condSource,
  input wire logic [STD_WIDTH-1:0] stdEventSet,
  input wire ser_cmd_s cmd,
  input wire ser_action_s action,
  input wire logic [WIDTH-1:0] queryData,
  input wire logic queryValid,
  input wire logic quesSummary,
  input wire logic esbSummary,
  input wire logic clearStatusByte,
  input wire logic clearErrorQueue,
  input wire logic clearOutputQueue
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  query_answer_a: assert property (cmd.query |=> queryValid) else $error("no answer");
  answer_only_a: assert property (!cmd.query |=> !queryValid) else $error("stray answer");
  // Condition is the source one edge late, so two back here
  cond_live_a: assert property ((cmd.query && cmd.sel == SER_SEL_QCOND && $past(rstn))
    |=> queryData == $past(condSource, 2)) else $error("condition not live");
  // Two reads one idle cycle apart with a quiet source: second sees nothing
  read_clears_a: assert property ((cmd.query && cmd.sel == SER_SEL_QEVENT && $stable(condSource)
    && $past(rstn)) ##1 $stable(condSource)
    ##1 (cmd.query && cmd.sel == SER_SEL_QEVENT && $stable(condSource))
    |=> queryData == '0) else $error("event read kept bits");
  ques_clear_a: assert property ((action.clearStatus && $stable(condSource) && $past(rstn))
    ##1 $stable(condSource) |=> !quesSummary) else $error("ques summary after clear");
  esb_clear_a: assert property ((action.clearStatus && stdEventSet == '0)
    ##1 (stdEventSet == '0) |=> !esbSummary) else $error("esb summary after clear");
  clear_pulse_a: assert property (action.clearStatus |=> clearStatusByte && clearErrorQueue)
    else $error("clear pulses missing");
  clear_only_a: assert property (!action.clearStatus |=> !clearStatusByte && !clearErrorQueue)
    else $error("stray clear pulse");
  outq_clear_a: assert property (1'h1 |=> clearOutputQueue ==
    $past(action.clearStatus && action.afterTerminator)) else $error("output queue clear wrong");
  cover property (cmd.query && cmd.sel == SER_SEL_QEVENT);
  cover property (action.clearStatus && action.afterTerminator);
  cover property (quesSummary);
endmodule : ser_status_event_properties
bind ser_status_event ser_status_event_properties #(.WIDTH(WIDTH), .STD_WIDTH(STD_WIDTH)) chk (
  .clk(clk), .rstn(rstn), .condSource(condSource), .stdEventSet(stdEventSet), .cmd(cmd),
  .action(action), .queryData(queryData), .queryValid(queryValid), .quesSummary(quesSummary),
  .esbSummary(esbSummary), .clearStatusByte(clearStatusByte),
  .clearErrorQueue(clearErrorQueue), .clearOutputQueue(clearOutputQueue));

// file: verif/testbench.sv
// Purpose: scenario bench. Assumes: 250 MHz clock. Notes: host model issues commands
`timescale 1ns/1ps
module testbench;
  import ser_pkg::*;
  logic clk, rstn, qv, qs, es, csb, ceq, coq;
  logic [SER_WIDTH-1:0] cs, qd;
  logic [SER_STD_WIDTH-1:0] se;
  ser_cmd_s cmd;
  ser_action_s act;
  int failures, tests_run;
  ser_status_event DUT (.clk(clk), .rstn(rstn), .condSource(cs), .stdEventSet(se), .cmd(cmd),
    .action(act), .queryData(qd), .queryValid(qv), .quesSummary(qs), .esbSummary(es),
    .clearStatusByte(csb), .clearErrorQueue(ceq), .clearOutputQueue(coq));
  ser_host host (.clk(clk), .cmd(cmd), .action(act), .queryData(qd), .queryValid(qv));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input string n, input logic [SER_WIDTH-1:0] e, input logic [SER_WIDTH-1:0] g);
    tests_run++;
    if (e !== g) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask : chk
  task automatic q(input ser_sel_e s, input logic [SER_WIDTH-1:0] e);
    logic [SER_WIDTH-1:0] d;
    logic v;
    host.qry(s, d, v);
    chk("queryValid", 16'h0001, {15'h0000, v});
    chk(s.name(), e, d);
  endtask : q
  task automatic setc(input logic [SER_WIDTH-1:0] v);
    @(posedge clk) #1 cs = v;
    repeat (3) @(posedge clk);
  endtask : setc
  task automatic filters;
    // Event lands on the same edge as the clearing read
    fork
      q(SER_SEL_QEVENT, 16'h0000);
      @(posedge clk) #1 cs = 16'h0001;
    join
    q(SER_SEL_QEVENT, 16'h0001);
    host.wr(SER_SEL_QPTR, 16'h0005);
    host.wr(SER_SEL_QNTR, 16'h0006);
    setc(16'h000F);
    q(SER_SEL_QEVENT, 16'h0004);
    setc(16'h0000);
    q(SER_SEL_QEVENT, 16'h0006);
    q(SER_SEL_QEVENT, 16'h0000);
  endtask : filters
  task automatic summary;
    setc(16'h00F4);
    q(SER_SEL_QCOND, 16'h00F4);
    host.wr(SER_SEL_QENABLE, 16'h0004);
    repeat (3) @(posedge clk);
    #1;
    chk("quesSummary", 16'h0001, {15'h0000, qs});
    host.act('{1'h0, 1'h0, 1'h0, 1'h1});
    q(SER_SEL_QCOND, 16'h00F4);
    q(SER_SEL_QEVENT, 16'h0004);
    setc(16'h0000);
    host.act('{1'h1, 1'h0, 1'h0, 1'h0});
    chk("clearStatusByte", 16'h0001, {15'h0000, csb});
    chk("clearErrorQueue", 16'h0001, {15'h0000, ceq});
    chk("clearOutputQueue", 16'h0000, {15'h0000, coq});
    repeat (2) @(posedge clk);
    #1;
    chk("quesSummary", 16'h0000, {15'h0000, qs});
    q(SER_SEL_QENABLE, 16'h0004);
    q(SER_SEL_QEVENT, 16'h0000);
  endtask : summary
  task automatic std_events;
    @(posedge clk) #1 se = 8'h18;
    @(posedge clk) #1 se = 8'h00;
    host.wr(SER_SEL_SENABLE, 16'h0010);
    repeat (3) @(posedge clk);
    #1;
    chk("esbSummary", 16'h0001, {15'h0000, es});
    q(SER_SEL_SEVENT, 16'h0018);
    q(SER_SEL_SEVENT, 16'h0000);
    host.act('{1'h1, 1'h1, 1'h0, 1'h0});
    chk("clearOutputQueue", 16'h0001, {15'h0000, coq});
    chk("clearStatusByte", 16'h0001, {15'h0000, csb});
    q(SER_SEL_SENABLE, 16'h0010);
  endtask : std_events
  task automatic preset;
    host.wr(SER_SEL_QPTR, 16'h0000);
    host.wr(SER_SEL_QNTR, 16'h00FF);
    host.act('{1'h0, 1'h0, 1'h1, 1'h0});
    q(SER_SEL_QPTR, SER_ALL_ONE);
    q(SER_SEL_QNTR, SER_ALL_ZERO);
    q(SER_SEL_QENABLE, SER_ALL_ZERO);
  endtask : preset
  task automatic finish_test;
    if (failures == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  initial begin
    rstn = 1'h0;
    cs = SER_ALL_ZERO;
    se = SER_STD_ZERO;
    failures = 0;
    tests_run = 0;
    repeat (3) @(posedge clk);
    #1 rstn = 1'h1;
    filters;
    summary;
    std_events;
    preset;
    finish_test;
  end
  initial begin
    #100000;
    failures++;
    finish_test;
  end
endmodule : testbench
